// ===== src/cip_pkg.sv
// constants, register map and types for the configurable i/o ports
package cip_pkg;
  localparam int NPORTS = 4;
  localparam int PW = 8;

  // port indices
  localparam logic [1:0] PORT1 = 2'h0;
  localparam logic [1:0] PORT2 = 2'h1;
  localparam logic [1:0] PORT3 = 2'h2;
  localparam logic [1:0] PORT4 = 2'h3;

  // register address layout: addr[4:2] register kind, addr[1:0] port
  localparam int ADDR_W = 8;
  localparam int KIND_LSB = 2;
  localparam logic [2:0] KIND_DATA_IN = 3'h0;
  localparam logic [2:0] KIND_DATA_OUT = 3'h1;
  localparam logic [2:0] KIND_DIR = 3'h2;
  localparam logic [2:0] KIND_DRIVE = 3'h3;
  localparam logic [2:0] KIND_FSEL = 3'h4;
  localparam logic [2:0] KIND_ENABLE_OUT = 3'h5;
  localparam logic [2:0] KIND_BUS_MODE = 3'h6;
  localparam logic [2:0] KIND_INPUT_CELL = 3'h7;

  // reset value of every configuration register
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // bus mode register field
  localparam int PERIPH_BIT = 7;
  localparam logic [7:0] BUS_MODE_MASK = 8'h80;

  // implemented bits per port
  localparam logic [7:0] PORT4_MASK = 8'h07;
  localparam logic [3:0] FSEL_PORTS = 4'h3;

  // drive select meaning per port
  localparam logic [7:0] OD_MASK_AB = 8'hf0;
  localparam logic [7:0] SLEW_MASK_AB = 8'h0f;
  localparam logic [7:0] OD_MASK_C = 8'hff;
  localparam logic [7:0] SLEW_MASK_C = 8'h00;
  localparam logic [7:0] OD_MASK_D = 8'h00;
  localparam logic [7:0] SLEW_MASK_D = 8'h07;

  // scan programming pins on the third port
  localparam logic [7:0] SCAN_PIN_MASK = 8'h0f;
  localparam int SCAN_OUT_PIN = 3;

  typedef enum logic [1:0] {
    CIP_BUS_MUX = 2'b00,
    CIP_BUS_NONMUX = 2'b01,
    CIP_BUS_VAR_A = 2'b10,
    CIP_BUS_PAGE = 2'b11
  } cip_bus_t;
endpackage

// ===== src/cip_port_pin.sv
// output path of one port: function mux, enable, drive style, override
`timescale 1ns/1ps
module cip_port_pin (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [7:0] data_out_i,
  input wire logic [7:0] dir_i,
  input wire logic [7:0] oe_term_i,
  input wire logic [7:0] alt_sel_i,
  input wire logic [7:0] alt_data_i,
  input wire logic [7:0] drive_i,
  input wire logic [7:0] od_mask_i,
  input wire logic [7:0] slew_mask_i,
  input wire logic [7:0] ovr_en_i,
  input wire logic [7:0] ovr_oe_i,
  input wire logic [7:0] ovr_data_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] fast_slew_o
);
  logic [7:0] val_d;
  logic [7:0] en_d;
  logic [7:0] od_d;
  logic [7:0] oe_d;
  logic [7:0] out_d;

  always_comb begin
    val_d = (alt_sel_i & alt_data_i) | (~alt_sel_i & data_out_i);
    en_d = dir_i | oe_term_i;
    od_d = drive_i & od_mask_i;
    // open drain only pulls low here; the overrides below replace both enable and data
    oe_d = en_d & ~(od_d & val_d);
    out_d = val_d & ~od_d;
    oe_d = (ovr_en_i & ovr_oe_i) | (~ovr_en_i & oe_d);
    out_d = (ovr_en_i & ovr_data_i) | (~ovr_en_i & out_d);
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_o <= 8'h00;
      pin_oe_o <= 8'h00;
      fast_slew_o <= 8'h00;
    end else begin
      pin_o <= out_d;
      pin_oe_o <= oe_d;
      fast_slew_o <= drive_i & slew_mask_i;
    end
  end
endmodule

// ===== src/cip_io_ports.sv
// four configurable i/o ports with configuration registers and pin modes
`timescale 1ns/1ps
module cip_io_ports (
  input wire logic mclk_i,
  input wire logic nrst_i,
  // configuration register cycles
  input wire logic config_io_space_i,
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  // processor address and data lines
  input wire logic [15:0] cpu_addr_i,
  input wire logic address_latch_strobe_i,
  input wire logic [1:0] bus_type_i,
  input wire logic data_port_mode_i,
  input wire logic [7:0] cpu_data_i,
  input wire logic cpu_data_wr_i,
  output logic [7:0] cpu_data_o,
  // logic-array terms
  input wire logic periph_select_0_i,
  input wire logic periph_select_1_i,
  input wire logic [3:0][7:0] oe_term_i,
  input wire logic [3:0] ic_latch_en_i,
  input wire logic [3:0][7:0] decode_use_i,
  // scan programming
  input wire logic scan_select_equation_i,
  input wire logic scan_cfg_en_i,
  input wire logic scan_rt_en_i,
  input wire logic scan_out_i,
  input wire logic scan_out_en_i,
  output logic scan_active_o,
  output logic [7:0] scan_in_o,
  // pins
  input wire logic [3:0][7:0] pin_i,
  output logic [3:0][7:0] pin_o,
  output logic [3:0][7:0] pin_oe_o,
  output logic [3:0][7:0] pin_fast_slew_o,
  output logic [3:0][7:0] input_cell_o,
  output logic [3:0][7:0] addr_in_o
);
  logic [3:0][7:0] fsel_q;
  logic [3:0][7:0] dir_q;
  logic [3:0][7:0] drive_q;
  logic [3:0][7:0] dout_q;
  logic [7:0] bus_mode_q;
  logic [3:0][7:0] pin_s1_q;
  logic [3:0][7:0] pin_s2_q;
  logic [3:0][7:0] ic_q;
  logic [15:0] addr_lat_q;
  logic [7:0] rdata_q;
  logic [7:0] cpu_data_q;
  logic scan_active_q;
  logic [7:0] scan_in_q;
  logic [3:0][7:0] addr_in_q;

  logic wr_hit;
  logic rd_hit;
  logic [2:0] kind;
  logic [1:0] port;
  logic addr_ok;
  logic [3:0][7:0] alt_sel;
  logic [3:0][7:0] alt_data;
  logic [3:0][7:0] ovr_en;
  logic [3:0][7:0] ovr_oe;
  logic [3:0][7:0] ovr_data;
  logic periph_on;
  logic periph_sel;
  logic scan_on;
  logic [7:0] rd_val;

  // implemented bits of a register kind on a port
  function automatic logic [7:0] impl_mask(input logic [2:0] k, input logic [1:0] p);
    logic [7:0] m;
    m = (p == cip_pkg::PORT4) ? cip_pkg::PORT4_MASK : 8'hff;
    if (k == cip_pkg::KIND_FSEL && !cip_pkg::FSEL_PORTS[p]) begin
      m = 8'h00;
    end
    return m;
  endfunction

  // address nibbles offered to port one and two, with availability
  function automatic logic [15:0] route_addr(input logic [1:0] bt, input logic [15:0] a,
                                             input logic want_mask);
    logic [15:0] d;
    logic [15:0] m;
    d = 16'h0000;
    m = 16'h0000;
    unique case (cip_pkg::cip_bus_t'(bt))
      cip_pkg::CIP_BUS_MUX: begin
        d = {a[7:0], a[7:0]};
        m = 16'hffff;
      end
      cip_pkg::CIP_BUS_NONMUX: begin
        d = {a[7:0], 8'h00};
        m = 16'hff00;
      end
      cip_pkg::CIP_BUS_VAR_A: begin
        d = {4'h0, a[11:8], a[7:4], 4'h0};
        m = 16'h0ff0;
      end
      cip_pkg::CIP_BUS_PAGE: begin
        d = {a[15:12], a[11:8], 8'h00};
        m = 16'hff00;
      end
    endcase
    return want_mask ? m : d;
  endfunction

  assign kind = cfg_addr_i[cip_pkg::KIND_LSB +: 3];
  assign port = cfg_addr_i[1:0];
  assign addr_ok = (cfg_addr_i[7:5] == 3'h0) &&
                   ((kind != cip_pkg::KIND_BUS_MODE) || (port == cip_pkg::PORT1));
  assign wr_hit = config_io_space_i & cfg_wr_i & addr_ok;
  assign rd_hit = config_io_space_i & cfg_rd_i;

  // configuration registers
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fsel_q <= {4{cip_pkg::CFG_RST}};
    end else if (wr_hit && kind == cip_pkg::KIND_FSEL) begin
      fsel_q[port] <= cfg_wdata_i & impl_mask(kind, port);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dir_q <= {4{cip_pkg::CFG_RST}};
    end else if (wr_hit && kind == cip_pkg::KIND_DIR) begin
      dir_q[port] <= cfg_wdata_i & impl_mask(kind, port);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drive_q <= {4{cip_pkg::CFG_RST}};
    end else if (wr_hit && kind == cip_pkg::KIND_DRIVE) begin
      drive_q[port] <= cfg_wdata_i & impl_mask(kind, port);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dout_q <= {4{cip_pkg::CFG_RST}};
    end else if (wr_hit && kind == cip_pkg::KIND_DATA_OUT) begin
      dout_q[port] <= cfg_wdata_i & impl_mask(kind, port);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_mode_q <= cip_pkg::CFG_RST;
    end else if (wr_hit && kind == cip_pkg::KIND_BUS_MODE) begin
      bus_mode_q <= cfg_wdata_i & cip_pkg::BUS_MODE_MASK;
    end
  end

  // pin synchroniser
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // latched processor address for address output mode
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_lat_q <= 16'h0000;
    end else if (address_latch_strobe_i) begin
      addr_lat_q <= cpu_addr_i;
    end
  end

  // input cells: latched on the strobe or transparent
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ic_q <= '0;
    end else begin
      for (int p = 0; p < cip_pkg::NPORTS; p++) begin
        if (!ic_latch_en_i[p] || address_latch_strobe_i) begin
          ic_q[p] <= pin_s2_q[p] & impl_mask(cip_pkg::KIND_INPUT_CELL, 2'(p));
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_in_q <= '0;
    end else begin
      for (int p = 0; p < cip_pkg::NPORTS; p++) begin
        addr_in_q[p] <= ic_q[p] & decode_use_i[p];
      end
    end
  end

  // mode overrides on ports one and three
  assign periph_on = bus_mode_q[cip_pkg::PERIPH_BIT];
  assign periph_sel = periph_select_0_i | periph_select_1_i;
  assign scan_on = scan_select_equation_i | scan_cfg_en_i | scan_rt_en_i;

  always_comb begin
    ovr_en = '0;
    ovr_oe = '0;
    ovr_data = '0;
    if (data_port_mode_i) begin
      ovr_en[cip_pkg::PORT1] = 8'hff;
      ovr_oe[cip_pkg::PORT1] = {8{cpu_data_wr_i}};
      ovr_data[cip_pkg::PORT1] = cpu_data_i;
    end else if (periph_on) begin
      ovr_en[cip_pkg::PORT1] = 8'hff;
      ovr_oe[cip_pkg::PORT1] = {8{cpu_data_wr_i & periph_sel}};
      ovr_data[cip_pkg::PORT1] = cpu_data_i;
    end
    if (scan_on) begin
      ovr_en[cip_pkg::PORT3] = cip_pkg::SCAN_PIN_MASK;
      ovr_oe[cip_pkg::PORT3][cip_pkg::SCAN_OUT_PIN] = scan_out_en_i;
      ovr_data[cip_pkg::PORT3][cip_pkg::SCAN_OUT_PIN] = scan_out_i;
    end
  end

  // address output selection; the host must also set direction
  always_comb begin
    alt_sel = '0;
    alt_data = '0;
    {alt_data[cip_pkg::PORT2], alt_data[cip_pkg::PORT1]} =
      route_addr(bus_type_i, addr_lat_q, 1'b0);
    {alt_sel[cip_pkg::PORT2], alt_sel[cip_pkg::PORT1]} =
      route_addr(bus_type_i, addr_lat_q, 1'b1) &
      {fsel_q[cip_pkg::PORT2], fsel_q[cip_pkg::PORT1]};
  end

  // one output path per port; port four sees only its three enable terms
  for (genvar g = 0; g < cip_pkg::NPORTS; g++) begin : g_port
    cip_port_pin u_port (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .data_out_i(dout_q[g]),
      .dir_i(dir_q[g]),
      .oe_term_i(oe_term_i[g] & impl_mask(cip_pkg::KIND_DIR, 2'(g))),
      .alt_sel_i(alt_sel[g]),
      .alt_data_i(alt_data[g]),
      .drive_i(drive_q[g]),
      .od_mask_i((g < 2) ? cip_pkg::OD_MASK_AB :
                 (g == 2) ? cip_pkg::OD_MASK_C : cip_pkg::OD_MASK_D),
      .slew_mask_i((g < 2) ? cip_pkg::SLEW_MASK_AB :
                   (g == 2) ? cip_pkg::SLEW_MASK_C : cip_pkg::SLEW_MASK_D),
      .ovr_en_i(ovr_en[g]),
      .ovr_oe_i(ovr_oe[g]),
      .ovr_data_i(ovr_data[g]),
      .pin_o(pin_o[g]),
      .pin_oe_o(pin_oe_o[g]),
      .fast_slew_o(pin_fast_slew_o[g])
    );
  end

  // register readback
  always_comb begin
    rd_val = cip_pkg::UNMAPPED_RD;
    if (addr_ok) begin
      unique case (kind)
        cip_pkg::KIND_DATA_IN: rd_val = pin_s2_q[port] & impl_mask(kind, port);
        cip_pkg::KIND_DATA_OUT: rd_val = dout_q[port];
        cip_pkg::KIND_DIR: rd_val = dir_q[port];
        cip_pkg::KIND_DRIVE: rd_val = drive_q[port];
        cip_pkg::KIND_FSEL: rd_val = fsel_q[port];
        cip_pkg::KIND_ENABLE_OUT: rd_val = pin_oe_o[port];
        cip_pkg::KIND_BUS_MODE: rd_val = bus_mode_q;
        cip_pkg::KIND_INPUT_CELL: rd_val = ic_q[port];
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_hit ? rd_val : 8'h00;
    end
  end

  // processor data lines from port one in data port mode, or in peripheral mode while a peripheral select term is set
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cpu_data_q <= 8'h00;
    end else if (data_port_mode_i || (periph_on && periph_sel)) begin
      cpu_data_q <= pin_s2_q[cip_pkg::PORT1];
    end else begin
      cpu_data_q <= 8'h00;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scan_active_q <= 1'b0;
      scan_in_q <= 8'h00;
    end else begin
      scan_active_q <= scan_on;
      scan_in_q <= scan_on ? (pin_s2_q[cip_pkg::PORT3] & cip_pkg::SCAN_PIN_MASK) : 8'h00;
    end
  end

  assign cfg_rdata_o = rdata_q;
  assign cpu_data_o = cpu_data_q;
  assign scan_active_o = scan_active_q;
  assign scan_in_o = scan_in_q;
  assign input_cell_o = ic_q;
  assign addr_in_o = addr_in_q;
endmodule

// ===== dv/cip_io_ports_asserts.sv
// concurrent checks on the configurable i/o port outputs
`timescale 1ns/1ps
module cip_io_ports_chk (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic config_io_space_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic data_port_mode_i,
  input wire logic [7:0] cpu_data_i,
  input wire logic cpu_data_wr_i,
  input wire logic [3:0][7:0] oe_term_i,
  input wire logic scan_select_equation_i,
  input wire logic scan_cfg_en_i,
  input wire logic scan_rt_en_i,
  input wire logic scan_active_o,
  input wire logic [3:0][7:0] pin_o,
  input wire logic [3:0][7:0] pin_oe_o,
  input wire logic [3:0][7:0] pin_fast_slew_o
);
  logic [2:0] oe4_q;
  logic scan_req;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  assign scan_req = scan_select_equation_i | scan_cfg_en_i | scan_rt_en_i;
  // enable terms of the three-pin port seen last edge
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oe4_q <= 3'h0;
    end else begin
      oe4_q <= oe_term_i[3][2:0];
    end
  end
  chk_reset_all_input: assert property ($rose(nrst_i) |->
    pin_oe_o == 32'h0000_0000 && cfg_rdata_o == 8'h00) else $error("pins drive after reset");
  chk_unmapped_read: assert property (config_io_space_i && cfg_rd_i &&
    cfg_addr_i[7:5] != 3'h0 |=> cfg_rdata_o == 8'h00) else $error("unmapped read not zero");
  chk_rdata_idle: assert property (!(config_io_space_i && cfg_rd_i) |=>
    cfg_rdata_o == 8'h00) else $error("read data without read");
  chk_port4_upper: assert property (pin_oe_o[3][7:3] == 5'h00 &&
    pin_fast_slew_o[3][7:3] == 5'h00) else $error("absent pins of port four active");
  chk_slew_masks: assert property (pin_fast_slew_o[0][7:4] == 4'h0 &&
    pin_fast_slew_o[1][7:4] == 4'h0 && pin_fast_slew_o[2] == 8'h00) else $error("slew bit misplaced");
  chk_data_port_drive: assert property (data_port_mode_i && cpu_data_wr_i |=>
    pin_oe_o[0] == 8'hff && pin_o[0] == $past(cpu_data_i)) else $error("data port not driven");
  chk_data_port_idle: assert property (data_port_mode_i && !cpu_data_wr_i |=>
    pin_oe_o[0] == 8'h00) else $error("data port drives while idle");
  chk_oe_term_or: assert property (oe4_q != 3'h0 |->
    (pin_oe_o[3][2:0] & oe4_q) == oe4_q) else $error("enable term not ored in");
  chk_scan_enable: assert property (scan_req |=> scan_active_o)
    else $error("scan not enabled");
  chk_scan_off: assert property (!scan_req |=> !scan_active_o)
    else $error("scan enabled without source");
endmodule
bind cip_io_ports cip_io_ports_chk cip_io_ports_chk_inst (.mclk_i, .nrst_i,
  .config_io_space_i, .cfg_rd_i, .cfg_addr_i, .cfg_rdata_o, .data_port_mode_i,
  .cpu_data_i, .cpu_data_wr_i, .oe_term_i, .scan_select_equation_i, .scan_cfg_en_i,
  .scan_rt_en_i, .scan_active_o, .pin_o, .pin_oe_o, .pin_fast_slew_o);

// ===== dv/cip_host_model.sv
// host processor model issuing configuration register cycles
`timescale 1ns/1ps
module cip_host_model (
  input wire logic mclk_i,
  output logic config_io_space_o,
  output logic cfg_rd_o,
  output logic cfg_wr_o,
  output logic [7:0] cfg_addr_o,
  output logic [7:0] cfg_wdata_o,
  input wire logic [7:0] cfg_rdata_i
);
  initial begin
    config_io_space_o = 1'b0;
    cfg_rd_o = 1'b0;
    cfg_wr_o = 1'b0;
    cfg_addr_o = 8'h00;
    cfg_wdata_o = 8'h00;
  end
  // idle bus lines flip so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    config_io_space_o = 1'b1;
    cfg_wr_o = 1'b1;
    cfg_addr_o = a;
    cfg_wdata_o = d;
    @(negedge mclk_i);
    config_io_space_o = 1'b0;
    cfg_wr_o = 1'b0;
    cfg_addr_o = ~a;
    cfg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    config_io_space_o = 1'b1;
    cfg_rd_o = 1'b1;
    cfg_addr_o = a;
    @(negedge mclk_i);
    d = cfg_rdata_i;
    config_io_space_o = 1'b0;
    cfg_rd_o = 1'b0;
    cfg_addr_o = ~a;
  endtask
  // address output needs select and direction both set
  task automatic addr_out(input logic [1:0] p, input logic [7:0] b);
    wr({3'h0, cip_pkg::KIND_FSEL, p}, b);
    wr({3'h0, cip_pkg::KIND_DIR, p}, b);
  endtask
endmodule

// ===== dv/configurable_io_port_modes_test.sv
// self-checking bench for the configurable i/o ports
`timescale 1ns/1ps
module configurable_io_port_modes_test;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic config_io_space_i, cfg_rd_i, cfg_wr_i;
  logic [7:0] cfg_addr_i, cfg_wdata_i, cfg_rdata_o, cpu_data_o, scan_in_o, rv;
  logic [15:0] cpu_addr_i = 16'h0000;
  logic [7:0] cpu_data_i = 8'h00;
  logic [1:0] bus_type_i = 2'h0;
  logic [3:0] ic_latch_en_i = 4'h0;
  logic address_latch_strobe_i = 1'b0;
  logic data_port_mode_i = 1'b0;
  logic cpu_data_wr_i = 1'b0;
  logic periph_select_0_i = 1'b0;
  logic periph_select_1_i = 1'b0;
  logic scan_select_equation_i = 1'b0;
  logic scan_cfg_en_i = 1'b0;
  logic scan_rt_en_i = 1'b0;
  logic scan_out_i = 1'b0;
  logic scan_out_en_i = 1'b0;
  logic scan_active_o;
  logic [3:0][7:0] oe_term_i = 32'h0000_0000;
  logic [3:0][7:0] decode_use_i = 32'h0000_0000;
  logic [3:0][7:0] pin_i = 32'h0000_0000;
  logic [3:0][7:0] pin_o, pin_oe_o, pin_fast_slew_o, input_cell_o, addr_in_o;
  logic [3:0][7:0] slew_exp = 32'h0700_0f0f;
  logic [3:0][15:0] aexp = 64'h1200_0230_3400_3434;
  int err_count = 0;
  int checks_done = 0;

  always #2 mclk_i = ~mclk_i;

  cip_host_model cip_host_model_inst (.mclk_i, .config_io_space_o(config_io_space_i),
    .cfg_rd_o(cfg_rd_i), .cfg_wr_o(cfg_wr_i), .cfg_addr_o(cfg_addr_i),
    .cfg_wdata_o(cfg_wdata_i), .cfg_rdata_i(cfg_rdata_o));
  cip_io_ports cip_io_ports_inst (.mclk_i, .nrst_i, .config_io_space_i, .cfg_rd_i,
    .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o, .cpu_addr_i,
    .address_latch_strobe_i, .bus_type_i, .data_port_mode_i, .cpu_data_i,
    .cpu_data_wr_i, .cpu_data_o, .periph_select_0_i, .periph_select_1_i, .oe_term_i,
    .ic_latch_en_i, .decode_use_i, .scan_select_equation_i, .scan_cfg_en_i,
    .scan_rt_en_i, .scan_out_i, .scan_out_en_i, .scan_active_o, .scan_in_o, .pin_i,
    .pin_o, .pin_oe_o, .pin_fast_slew_o, .input_cell_o, .addr_in_o);

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] ra(input logic [2:0] k, input int p);
    return {3'h0, k, p[1:0]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cip_host_model_inst.wr(a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    cip_host_model_inst.rd(a, rv);
    chk8(rv, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic done(input string s);
    $display("test %s finished, %0d checks so far", s, checks_done);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    final_report();
  end

  initial begin
    cyc(6);
    nrst_i = 1'b1;
    for (int p = 0; p < 4; p++) begin
      rdc(ra(cip_pkg::KIND_DIR, p), 8'h00);
      rdc(ra(cip_pkg::KIND_DRIVE, p), 8'h00);
      rdc(ra(cip_pkg::KIND_FSEL, p), 8'h00);
    end
    chk8(pin_oe_o[0] | pin_oe_o[1] | pin_oe_o[2] | pin_oe_o[3], 8'h00);
    done("reset");
    for (int p = 0; p < 4; p++) begin
      wr(ra(cip_pkg::KIND_DIR, p), 8'h96);
      wr(ra(cip_pkg::KIND_DRIVE, p), 8'hff);
      wr(ra(cip_pkg::KIND_FSEL, p), 8'h3c);
      rdc(ra(cip_pkg::KIND_DIR, p), (p == 3) ? 8'h06 : 8'h96);
      rdc(ra(cip_pkg::KIND_DRIVE, p), (p == 3) ? 8'h07 : 8'hff);
      rdc(ra(cip_pkg::KIND_FSEL, p), (p < 2) ? 8'h3c : 8'h00);
    end
    cyc(1);
    for (int p = 0; p < 4; p++) begin
      chk8(pin_fast_slew_o[p], slew_exp[p]);
      chk8(pin_oe_o[p], (p == 3) ? 8'h06 : 8'h96);
    end
    wr(8'he0, 8'hff);
    rdc(8'he0, 8'h00);
    done("registers");
    for (int p = 0; p < 4; p++) begin
      wr(ra(cip_pkg::KIND_DRIVE, p), 8'h00);
      wr(ra(cip_pkg::KIND_FSEL, p), 8'h00);
    end
    wr(ra(cip_pkg::KIND_DATA_OUT, 1), 8'h5a);
    wr(ra(cip_pkg::KIND_DIR, 1), 8'hff);
    cyc(1);
    chk8(pin_o[1], 8'h5a);
    chk8(pin_oe_o[1], 8'hff);
    rdc(ra(cip_pkg::KIND_DATA_OUT, 1), 8'h5a);
    wr(ra(cip_pkg::KIND_DRIVE, 1), 8'hf0);
    cyc(1);
    chk8(pin_o[1], 8'h0a);
    chk8(pin_oe_o[1], 8'haf);
    rdc(ra(cip_pkg::KIND_ENABLE_OUT, 1), 8'haf);
    wr(ra(cip_pkg::KIND_DIR, 2), 8'h03);
    oe_term_i[2] = 8'h30;
    oe_term_i[3] = 8'h09;
    cyc(2);
    chk8(pin_oe_o[2], 8'h33);
    chk8(pin_oe_o[3], 8'h07);
    oe_term_i = 32'h0000_0000;
    cyc(2);
    chk8(pin_oe_o[2], 8'h03);
    done("drive");
    wr(ra(cip_pkg::KIND_DRIVE, 1), 8'h00);
    wr(ra(cip_pkg::KIND_DATA_OUT, 1), 8'h00);
    cip_host_model_inst.addr_out(2'h0, 8'hff);
    cip_host_model_inst.addr_out(2'h1, 8'hff);
    cpu_addr_i = 16'h1234;
    address_latch_strobe_i = 1'b1;
    cyc(1);
    address_latch_strobe_i = 1'b0;
    for (int b = 0; b < 4; b++) begin
      bus_type_i = b[1:0];
      cyc(2);
      chk8(pin_o[0], aexp[b][7:0]);
      chk8(pin_o[1], aexp[b][15:8]);
    end
    bus_type_i = 2'h0;
    wr(ra(cip_pkg::KIND_DATA_OUT, 0), 8'hc3);
    cyc(1);
    chk8(pin_o[0], 8'h34);
    wr(ra(cip_pkg::KIND_FSEL, 0), 8'h00);
    cyc(1);
    chk8(pin_o[0], 8'hc3);
    done("address out");
    data_port_mode_i = 1'b1;
    cpu_data_wr_i = 1'b1;
    cpu_data_i = 8'h96;
    cyc(2);
    chk8(pin_o[0], 8'h96);
    cpu_data_wr_i = 1'b0;
    pin_i[0] = 8'h69;
    cyc(4);
    chk8(cpu_data_o, 8'h69);
    chk8(pin_oe_o[0], 8'h00);
    data_port_mode_i = 1'b0;
    wr(8'h18, 8'h80);
    rdc(8'h18, 8'h80);
    cpu_data_wr_i = 1'b1;
    cyc(2);
    chk8(pin_oe_o[0], 8'h00);
    periph_select_1_i = 1'b1;
    cyc(2);
    chk8(pin_oe_o[0], 8'hff);
    chk8(pin_o[0], 8'h96);
    periph_select_1_i = 1'b0;
    periph_select_0_i = 1'b1;
    cyc(2);
    chk8(pin_oe_o[0], 8'hff);
    periph_select_0_i = 1'b0;
    cpu_data_wr_i = 1'b0;
    wr(8'h18, 8'h00);
    done("data port");
    pin_i[2] = 8'hf6;
    scan_out_en_i = 1'b1;
    scan_out_i = 1'b1;
    for (int s = 0; s < 3; s++) begin
      {scan_rt_en_i, scan_cfg_en_i, scan_select_equation_i} = 3'h1 << s;
      cyc(4);
      chk1(scan_active_o, 1'b1);
      chk8(scan_in_o, 8'h06);
      chk8(pin_oe_o[2] & 8'h0f, 8'h08);
      chk8(pin_o[2] & 8'h0f, 8'h08);
    end
    {scan_rt_en_i, scan_cfg_en_i, scan_select_equation_i} = 3'h0;
    scan_out_en_i = 1'b0;
    scan_out_i = 1'b0;
    cyc(2);
    chk1(scan_active_o, 1'b0);
    done("scan");
    ic_latch_en_i = 4'h4;
    decode_use_i[2] = 8'h0f;
    pin_i[2] = 8'h5a;
    cyc(4);
    address_latch_strobe_i = 1'b1;
    cyc(1);
    address_latch_strobe_i = 1'b0;
    pin_i[2] = 8'hff;
    cyc(4);
    chk8(input_cell_o[2], 8'h5a);
    chk8(addr_in_o[2], 8'h0a);
    rdc(ra(cip_pkg::KIND_INPUT_CELL, 2), 8'h5a);
    rdc(ra(cip_pkg::KIND_DATA_IN, 2), 8'hff);
    done("address in");
    final_report();
  end
endmodule
